/* pkg/mscr_defines.vh */
// constants for the module status/control register block
// assumes a serial-bus engine presents byte reads and writes by offset
// Function
// - volatile 8-bit status/control register at offset 6Eh, bit 7 reserved
// - page-one view bit 6 is channel-a software transmit disable, default 0
// - while set, low loss and power alarms do not latch after clearing
// - effect held the settling time after clearing, timer reloaded while set
// - page-two view bit 6 is channel-b disable, same behaviour as channel a
// - bit 5 read-only, mirrors the general input pin, shared by both pages
// - bit 4 read-only, mirrors the rate-select input pin, shared
// - bit 3 writable rate-select control, default 0, ORed onto rate output
// - bit 2 read-only, reflects the driven fault output level
// - bit 1 per page shows loss pin or fast low compare, by source select
// - bit 0 reads 1 while supply below trip level or too low for bus
// - at power-on bits 6 and 3 clear, others follow their sources
// - disable and loss bits per page; other bits shared between pages
// - fast low compare 1 when last compare below threshold, disable ignored
`ifndef MSCR_DEFINES_VH
`define MSCR_DEFINES_VH
`define MSCR_ADDR 8'h6e
`define MSCR_BIT_TXDIS 6
`define MSCR_BIT_GPIN 5
`define MSCR_BIT_RATE_SELECT_PIN_STATUS 4
`define MSCR_BIT_RATE_SELECT_SW_CONTROL 3
`define MSCR_BIT_FAULT 2
`define MSCR_BIT_RXL 1
`define MSCR_BIT_SUPPLY_NOT_READY 0
`define MSCR_HOLD_US 500
`define MSCR_CLK_MHZ 40
`define MSCR_HOLD_CYC (`MSCR_HOLD_US * `MSCR_CLK_MHZ)
`endif

/* src/mscr_status_control.v */
// status/control register at 6Eh with two page views
// assumes bus engine gives one-cycle write strobes and samples read data
`timescale 1ns/100ps
`default_nettype none
`include "mscr_defines.vh"
module mscr_status_control #(
  parameter HOLD_CYC = `MSCR_HOLD_CYC,
  parameter CNT_W = 16
) (
  input wire clock,
  input wire rst_n,
  input wire [7:0] busAddr,
  input wire pageSel,
  input wire busWrite,
  input wire [7:0] busWrData,
  output reg [7:0] busRdData,
  input wire generalInputPin,
  input wire rateSelectInputPin,
  input wire faultOutputLevel,
  input wire signalLossPinChA,
  input wire signalLossPinChB,
  input wire fastLowCompareChA,
  input wire fastLowCompareChB,
  input wire lossSourceSelect,
  input wire supplyNotReady,
  output wire rateSelectOutputPin,
  output wire alarmLatchInhibit
);
  reg swTxDisableChA_reg;
  reg swTxDisableChB_reg;
  reg rateSelectSwControl_reg;
  reg [CNT_W-1:0] holdA_reg;
  reg [CNT_W-1:0] holdB_reg;
  wire hit;
  wire rxLoss;
  localparam [CNT_W-1:0] HOLD_LOAD = HOLD_CYC[CNT_W-1:0];

  assign hit = (busAddr == `MSCR_ADDR);
  // page select: 0 = first receiver page, 1 = second
  assign rxLoss = pageSel ?
    (lossSourceSelect ? fastLowCompareChB : signalLossPinChB) :
    (lossSourceSelect ? fastLowCompareChA : signalLossPinChA);

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      swTxDisableChA_reg <= 1'b0;
      swTxDisableChB_reg <= 1'b0;
      rateSelectSwControl_reg <= 1'b0;
    end
    else if (busWrite && hit)
    begin
      // only bits 6 and 3 are writable
      if (pageSel)
        swTxDisableChB_reg <= busWrData[`MSCR_BIT_TXDIS];
      else
        swTxDisableChA_reg <= busWrData[`MSCR_BIT_TXDIS];
      rateSelectSwControl_reg <= busWrData[`MSCR_BIT_RATE_SELECT_SW_CONTROL];
    end
  end

  // hold timers restart while bit set, run down after clearing
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      holdA_reg <= {CNT_W{1'b0}};
      holdB_reg <= {CNT_W{1'b0}};
    end
    else
    begin
      if (swTxDisableChA_reg)
        holdA_reg <= HOLD_LOAD;
      else if (holdA_reg != {CNT_W{1'b0}})
        holdA_reg <= holdA_reg - 1'b1;
      if (swTxDisableChB_reg)
        holdB_reg <= HOLD_LOAD;
      else if (holdB_reg != {CNT_W{1'b0}})
        holdB_reg <= holdB_reg - 1'b1;
    end
  end

  assign alarmLatchInhibit = swTxDisableChA_reg | swTxDisableChB_reg |
    (holdA_reg != {CNT_W{1'b0}}) | (holdB_reg != {CNT_W{1'b0}});
  assign rateSelectOutputPin = rateSelectSwControl_reg |
    rateSelectInputPin;

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      busRdData <= 8'h00;
    else if (hit)
    begin
      busRdData[7] <= 1'b0;
      busRdData[`MSCR_BIT_TXDIS] <= pageSel ? swTxDisableChB_reg :
        swTxDisableChA_reg;
      busRdData[`MSCR_BIT_GPIN] <= generalInputPin;
      busRdData[`MSCR_BIT_RATE_SELECT_PIN_STATUS] <= rateSelectInputPin;
      busRdData[`MSCR_BIT_RATE_SELECT_SW_CONTROL] <= rateSelectSwControl_reg;
      busRdData[`MSCR_BIT_FAULT] <= faultOutputLevel;
      busRdData[`MSCR_BIT_RXL] <= rxLoss;
      busRdData[`MSCR_BIT_SUPPLY_NOT_READY] <= supplyNotReady;
    end
    else
      busRdData <= 8'h00;
  end
endmodule
`default_nettype wire

/* verification/mscr_status_control_sva.sv */
// port checker
// assumes hold over 8 cycles
`timescale 1ns/100ps
`default_nettype none
module mscr_status_control_sva(
  input wire logic clock, rst_n, busWrite, generalInputPin, supplyNotReady,
  input wire logic rateSelectInputPin, rateSelectOutputPin, alarmLatchInhibit,
  input wire logic [7:0] busAddr, busWrData, busRdData);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence sRd; busAddr == 8'h6e; endsequence
  sequence sWr; sRd ##0 busWrite; endsequence
  a_rate_or: assert property (
    rateSelectInputPin |-> rateSelectOutputPin) else $error("rate");
  a_rate_sw: assert property (
    sWr ##0 busWrData[3] |=> rateSelectOutputPin) else $error("rsw");
  a_inh_hold: assert property (
    sWr ##0 busWrData[6] |=> alarmLatchInhibit[*8]) else $error("inh");
  a_rd_other: assert property (
    busAddr != 8'h6e |=> busRdData == 8'h00) else $error("other");
  a_rd_resv: assert property (sRd |=> !busRdData[7]) else $error("rsv");
  a_rd_gpin: assert property (
    sRd |=> busRdData[5] == $past(generalInputPin)) else $error("gpin");
  a_rd_rate_select_input_pin: assert property (
    sRd |=> busRdData[4] == $past(rateSelectInputPin)) else $error("rate_select_input_pin");
  a_rd_ready: assert property (
    sRd |=> busRdData[0] == $past(supplyNotReady)) else $error("rdy");
endmodule
bind mscr_status_control mscr_status_control_sva u_sva(.*);
`default_nettype wire

/* verification/mscr_host.sv */
// host model, one byte access per call
// assumes a running clock
`timescale 1ns/100ps
`default_nettype none
module mscr_host(
  input wire logic clock,
  input wire logic [7:0] busRdData,
  output logic busWrite,
  output logic [7:0] busAddr, busWrData);
  initial {busWrite, busAddr, busWrData} = 17'h0;
  task acc(input logic w, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock) #2 {busWrite, busAddr, busWrData} = {w, 8'h6e, d};
    @(posedge clock) #2 q = busRdData;
    {busWrite, busAddr, busWrData} = {1'b0, 8'h00, ~d};
  endtask
endmodule
`default_nettype wire

/* verification/module_status_control_register_tb.sv */
// register bench
// assumes host model and checker
`timescale 1ns/100ps
`default_nettype none
module module_status_control_register_tb;
  logic clock = 0, rst_n = 0, pageSel = 0, lossSourceSelect = 0, busWrite;
  logic generalInputPin = 1, rateSelectInputPin = 0, faultOutputLevel = 1;
  logic signalLossPinChA = 1, signalLossPinChB = 0, supplyNotReady = 1;
  logic fastLowCompareChA = 0, fastLowCompareChB = 1;
  logic rateSelectOutputPin, alarmLatchInhibit;
  logic [7:0] busAddr, busWrData, busRdData, q;
  int bad_count = 0, compares = 0;
  always #12.5 clock = ~clock;
  mscr_status_control #(.HOLD_CYC(20)) u_dut(.*);
  mscr_host u_host(.*);
  task chk(input logic [7:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask
  task t_views;
    u_host.acc(0, 8'h00, q);
    chk(q, 8'h27);
    u_host.acc(1, 8'hff, q);
    u_host.acc(0, 8'h00, q);
    chk(q, 8'h6f);
    pageSel = 1;
    u_host.acc(0, 8'h00, q);
    chk(q, 8'h2d);
    lossSourceSelect = 1;
    u_host.acc(0, 8'h00, q);
    chk(q, 8'h2f);
  endtask
  task t_hold;
    pageSel = 0;
    u_host.acc(1, 8'h00, q);
    repeat (10) @(posedge clock);
    #2;
    chk({6'h00, rateSelectOutputPin, alarmLatchInhibit}, 8'h01);
    repeat (20) @(posedge clock);
    #2;
    chk({7'h00, alarmLatchInhibit}, 8'h00);
  endtask
  task test_done;
    if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clock);
    #2 rst_n = 1;
    t_views;
    t_hold;
    test_done;
  end
endmodule
`default_nettype wire
